// >>> verilog/misc_regs_pkg.sv
/*
 misc_regs_pkg: offsets, field positions, reset values and carriers for the
 miscellaneous control and identity register bank.
 assumes: Avalon-MM slave, 8-bit registers in the low bits of a 32-bit word.
*/
package misc_regs_pkg;
   localparam int unsigned ADDR_W           = 10;
   localparam int unsigned DATA_W           = 32;
   localparam int unsigned REG_W            = 8;
   localparam int unsigned CODE_W           = 10;
   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_RX_CODE_LOW   = 8'h62;
   localparam logic [7:0] IDX_RX_CODE_HIGH  = 8'h63;
   localparam logic [7:0] IDX_ROM_VER       = 8'h70;
   localparam logic [7:0] IDX_RAM_MAJOR     = 8'h71;
   localparam logic [7:0] IDX_RAM_MINOR     = 8'h72;
   localparam logic [7:0] IDX_PART_ID_LOW   = 8'h80;
   localparam logic [7:0] IDX_PART_ID_HIGH  = 8'h81;
   localparam logic [7:0] IDX_MISC_CONTROL  = 8'hee;
   // misc_control fields
   localparam int unsigned BIT_SOFT_RESET   = 0;
   localparam int unsigned BIT_CODE_STORE   = 1;
   localparam int unsigned BIT_IRQ_POLARITY = 2;
   localparam logic [2:0] MISC_CONTROL_MASK = 3'h7;
   localparam logic [2:0] MISC_CONTROL_RST  = 3'h0;
   localparam logic [1:0] RX_HIGH_RST       = 2'h0;
   localparam logic [7:0] RX_LOW_RST        = 8'h00;
   // arbitrary neutral identity defaults
   localparam logic [7:0] ROM_VER_DEFAULT   = 8'h11;
   localparam logic [15:0] PART_ID_DEFAULT  = 16'h5aa5;
   localparam logic [7:0] RAM_VER_RST       = 8'h00;
   localparam logic [31:0] READ_UNMAPPED    = 32'h0000_0000;

   typedef struct packed {
      logic irq_polarity_select;
      logic code_store_select;
      logic controller_soft_reset;
   } misc_control_s;

   typedef struct packed {
      logic [7:0] ram_major_version_field;
      logic [7:0] ram_minor_version_field;
   } ram_version_s;
endpackage : misc_regs_pkg

// >>> verilog/irq_pin_driver.sv
/*
 irq_pin_driver: turns the combined interrupt request into the host irq pin
 as output value and output enable.
 assumes: the wire is pulled up externally in active-low mode.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic irq_request,
   input  wire logic irq_polarity_select,
   output var  logic host_irq_output_o,
   output var  logic host_irq_output_oe
);
   import misc_regs_pkg::*;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         host_irq_output_o  <= 1'b0;
         host_irq_output_oe <= 1'b0;
      end else if (irq_polarity_select) begin
         host_irq_output_o  <= irq_request;
         host_irq_output_oe <= 1'b1;
      end else begin
         host_irq_output_o  <= 1'b0;
         host_irq_output_oe <= irq_request;
      end
   end
endmodule : irq_pin_driver
`default_nettype wire

// >>> verilog/rx_code_capture.sv
/*
 rx_code_capture: holds the ten-bit antenna receive code word, loaded by the
 antenna interface logic or by host writes to the two data registers.
 assumes: load strobe and code come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_code_capture (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        code_load,
   input  wire logic [9:0]  code_in,
   input  wire logic        host_wr_low,
   input  wire logic        host_wr_high,
   input  wire logic [7:0]  host_wdata,
   output var  logic [9:0]  code_q
);
   import misc_regs_pkg::*;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         code_q <= {RX_HIGH_RST, RX_LOW_RST};
      end else if (code_load) begin
         code_q <= code_in;
      end else begin
         if (host_wr_low) begin
            code_q[7:0] <= host_wdata;
         end
         if (host_wr_high) begin
            code_q[9:8] <= host_wdata[1:0];
         end
      end
   end
endmodule : rx_code_capture
`default_nettype wire

// >>> verilog/misc_control_id_registers.sv
/*
 misc_control_id_registers: Avalon-MM register bank with receive code word,
 firmware version, part identifier and miscellaneous control registers.
 assumes: one clock, synchronous active-low reset, status inputs synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module misc_control_id_registers (
   input  wire logic                              core_clk,
   input  wire logic                              resetn,
   input  wire logic [misc_regs_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                              avs_read,
   input  wire logic                              avs_write,
   input  wire logic [misc_regs_pkg::DATA_W-1:0]  avs_writedata,
   input  wire logic [3:0]                        avs_byteenable,
   output var  logic [misc_regs_pkg::DATA_W-1:0]  avs_readdata,
   output var  logic                              avs_waitrequest,
   input  wire logic                              rx_code_load,
   input  wire logic [misc_regs_pkg::CODE_W-1:0]  rx_code_in,
   input  wire misc_regs_pkg::ram_version_s       ram_version_in,
   input  wire logic                              ram_version_load,
   input  wire logic [7:0]                        unmasked_status,
   output var  misc_regs_pkg::misc_control_s      misc_control_out,
   output var  logic                              host_irq_output_o,
   output var  logic                              host_irq_output_oe
);
   import misc_regs_pkg::*;

   logic                ack_q;
   logic [DATA_W-1:0]   rdata_d;
   logic                access;
   logic                wr_take;
   logic [7:0]          idx;
   logic                word_aligned;
   logic [9:0]          code_q;
   misc_control_s       ctrl_q;
   ram_version_s        ram_ver_q;
   logic                irq_req_q;
   logic [7:0]          wbyte;

   assign access       = (avs_read | avs_write) & ~ack_q;
   assign wr_take      = avs_write & ack_q & avs_byteenable[0];
   assign idx          = avs_address[9:2];
   assign word_aligned = (avs_address[1:0] == 2'h0);
   assign wbyte        = avs_writedata[7:0];

   // one wait cycle, answer on the second edge of a request
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~access;
      end
   end

   always_comb begin
      rdata_d = READ_UNMAPPED;
      if (word_aligned) begin
         unique case (idx)
            IDX_RX_CODE_LOW:  rdata_d[7:0] = code_q[7:0];
            IDX_RX_CODE_HIGH: rdata_d[1:0] = code_q[9:8];
            IDX_ROM_VER:      rdata_d[7:0] = ROM_VER_DEFAULT;
            IDX_RAM_MAJOR:    rdata_d[7:0] = ram_ver_q.ram_major_version_field;
            IDX_RAM_MINOR:    rdata_d[7:0] = ram_ver_q.ram_minor_version_field;
            IDX_PART_ID_LOW:  rdata_d[7:0] = PART_ID_DEFAULT[7:0];
            IDX_PART_ID_HIGH: rdata_d[7:0] = PART_ID_DEFAULT[15:8];
            IDX_MISC_CONTROL: rdata_d[2:0] = ctrl_q;
            default:          rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         avs_readdata <= READ_UNMAPPED;
      end else if (avs_read & ~ack_q) begin
         avs_readdata <= rdata_d;
      end
   end

   // control writes keep only the three defined bits
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ctrl_q <= MISC_CONTROL_RST;
      end else if (wr_take & word_aligned & (idx == IDX_MISC_CONTROL)) begin
         ctrl_q <= wbyte[2:0] & MISC_CONTROL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         misc_control_out <= MISC_CONTROL_RST;
      end else begin
         misc_control_out.irq_polarity_select   <= ctrl_q[BIT_IRQ_POLARITY];
         misc_control_out.code_store_select     <= ctrl_q[BIT_CODE_STORE];
         misc_control_out.controller_soft_reset <= ctrl_q[BIT_SOFT_RESET];
      end
   end

   // version of code loaded into ram, reported by the controller
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ram_ver_q <= {RAM_VER_RST, RAM_VER_RST};
      end else if (ram_version_load) begin
         ram_ver_q <= ram_version_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         irq_req_q <= 1'b0;
      end else begin
         irq_req_q <= |unmasked_status;
      end
   end

   rx_code_capture u_rx_code (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .code_load    (rx_code_load),
      .code_in      (rx_code_in),
      .host_wr_low  (wr_take & word_aligned & (idx == IDX_RX_CODE_LOW)),
      .host_wr_high (wr_take & word_aligned & (idx == IDX_RX_CODE_HIGH)),
      .host_wdata   (wbyte),
      .code_q       (code_q)
   );

   irq_pin_driver u_irq (
      .core_clk            (core_clk),
      .resetn              (resetn),
      .irq_request         (irq_req_q),
      .irq_polarity_select (ctrl_q[BIT_IRQ_POLARITY]),
      .host_irq_output_o   (host_irq_output_o),
      .host_irq_output_oe  (host_irq_output_oe)
   );
endmodule : misc_control_id_registers
`default_nettype wire

// >>> dv/regs_monitor.sv
/* regs_monitor: port assertions for the register bank.
   assumes: bound into misc_control_id_registers, single clock. */
`timescale 1ns/1ps
`default_nettype none
module regs_monitor
   import misc_regs_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          resetn,
   input wire logic [9:0]    avs_address,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_writedata,
   input wire logic [3:0]    avs_byteenable,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest,
   input wire logic [7:0]    unmasked_status,
   input wire misc_regs_pkg::misc_control_s misc_control_out,
   input wire logic          host_irq_output_o,
   input wire logic          host_irq_output_oe
);
   wire logic       pol = misc_control_out.irq_polarity_select;
   wire logic       req = |unmasked_status;
   wire logic [2:0] wctl = avs_writedata[2:0];
   wire logic       done = !avs_waitrequest && avs_address[1:0] == 2'h0;
   wire logic       hit = done && avs_read;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_rsvd_high: assert property (hit && avs_address == 10'h18c |-> avs_readdata[31:2] == 30'h0)
      else $error("reserved code bits not zero");
   a_rom_ver: assert property (hit && avs_address == 10'h1c0 |-> avs_readdata == 32'h11)
      else $error("rom version wrong");
   a_id_low: assert property (hit && avs_address == 10'h200 |-> avs_readdata == 32'ha5)
      else $error("identifier low byte wrong");
   a_id_high: assert property (hit && avs_address == 10'h204 |-> avs_readdata == 32'h5a)
      else $error("identifier high byte wrong");
   a_ctrl_write: assert property (
      done && avs_write && avs_address == 10'h3b8 && avs_byteenable[0]
      |-> ##2 misc_control_out == $past(wctl, 2)) else $error("control output not updated");
   a_irq_low: assert property (
      !pol && !$past(pol) |-> !host_irq_output_o && host_irq_output_oe == $past(req, 2))
      else $error("active-low pin wrong");
   a_irq_high: assert property (
      pol && $past(pol) |-> host_irq_output_oe && host_irq_output_o == $past(req, 2))
      else $error("active-high pin wrong");
endmodule : regs_monitor
bind misc_control_id_registers regs_monitor u_regs_monitor (.core_clk, .resetn, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .unmasked_status, .misc_control_out, .host_irq_output_o, .host_irq_output_oe);
`default_nettype wire

// >>> dv/host_model.sv
/* host_model: host processor issuing Avalon-MM register cycles.
   assumes: slave answers by dropping waitrequest. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        core_clk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output var  logic [9:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic [3:0]  avs_byteenable
);
   initial begin
      avs_address = 10'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d,
                         input logic be, output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= {3'h0, be};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest) @(posedge core_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~avs_writedata;
   endtask : access
endmodule : host_model
`default_nettype wire

// >>> dv/misc_control_id_registers_test.sv
/* misc_control_id_registers_test: self-checking bench for the register bank.
   assumes: host_model drives the bus, checker bound separately. */
`timescale 1ns/1ps
`default_nettype none
module misc_control_id_registers_test;
   import misc_regs_pkg::*;
   logic core_clk, resetn, rx_code_load, ram_version_load, avs_waitrequest;
   logic avs_read, avs_write, host_irq_output_o, host_irq_output_oe;
   logic [9:0] rx_code_in, avs_address;
   logic [7:0] unmasked_status;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   ram_version_s ram_version_in;
   misc_control_s misc_control_out;
   int n_errors, tests_run, cycles;
   misc_control_id_registers u_misc_control_id_registers (.core_clk, .resetn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .rx_code_load, .rx_code_in, .ram_version_in, .ram_version_load, .unmasked_status,
      .misc_control_out, .host_irq_output_o, .host_irq_output_oe);
   host_model u_host_model (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
   task automatic complete_run();
      if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      u_host_model.access(1'b0, {idx, 2'h0}, 8'h0, 1'b0, rd);
      chk($sformatf("reg %h", idx), exp, rd);
   endtask : rchk
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic be);
      u_host_model.access(1'b1, {idx, 2'h0}, d, be, rd);
   endtask : wr
   task automatic s_reset_values();
      rchk(IDX_RX_CODE_HIGH, 32'h0);
      rchk(IDX_RAM_MINOR, 32'h0);
      rchk(IDX_MISC_CONTROL, 32'h0);
      rchk(IDX_ROM_VER, {24'h0, ROM_VER_DEFAULT});
      rchk(IDX_PART_ID_LOW, {24'h0, PART_ID_DEFAULT[7:0]});
      rchk(IDX_PART_ID_HIGH, {24'h0, PART_ID_DEFAULT[15:8]});
      rchk(8'hff, 32'h0);
   endtask : s_reset_values
   task automatic s_code_and_versions();
      @(posedge core_clk);
      rx_code_load <= 1'b1;
      ram_version_load <= 1'b1;
      @(posedge core_clk);
      rx_code_load <= 1'b0;
      ram_version_load <= 1'b0;
      rchk(IDX_RX_CODE_LOW, 32'hb6);
      rchk(IDX_RX_CODE_HIGH, 32'h2);
      wr(IDX_RX_CODE_HIGH, 8'hfd, 1'b1);
      rchk(IDX_RX_CODE_HIGH, 32'h1);
      wr(IDX_ROM_VER, 8'h5c, 1'b1);
      wr(IDX_RAM_MAJOR, 8'hff, 1'b1);
      rchk(IDX_ROM_VER, {24'h0, ROM_VER_DEFAULT});
      rchk(IDX_RAM_MAJOR, 32'h3);
      rchk(IDX_RAM_MINOR, 32'h4);
   endtask : s_code_and_versions
   task automatic s_control();
      for (int i = 0; i < 3; i++) begin
         wr(IDX_MISC_CONTROL, 8'hf8 | 8'(1 << i), 1'b1);
         rchk(IDX_MISC_CONTROL, 32'(1 << i));
         chk("control out", 32'(1 << i), {29'h0, misc_control_out});
      end
      wr(IDX_MISC_CONTROL, 8'h03, 1'b0);
      rchk(IDX_MISC_CONTROL, 32'h4);
   endtask : s_control
   task automatic s_irq_pin();
      for (int p = 0; p < 2; p++) begin
         wr(IDX_MISC_CONTROL, 8'(p << 2), 1'b1);
         for (int s = 0; s < 2; s++) begin
            unmasked_status <= 8'(s << 6);
            repeat (4) @(posedge core_clk);
            chk("irq pin", 32'(p ? 2 + s : 2 * s), {30'h0, host_irq_output_oe, host_irq_output_o});
         end
         unmasked_status <= 8'h0;
      end
   endtask : s_irq_pin
   task automatic s_reset_again();
      wr(IDX_MISC_CONTROL, 8'h07, 1'b1);
      unmasked_status <= 8'h01;
      repeat (3) @(posedge core_clk);
      chk("irq pin", 32'h3, {30'h0, host_irq_output_oe, host_irq_output_o});
      resetn <= 1'b0;
      unmasked_status <= 8'h0;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      chk("control out", 32'h0, {29'h0, misc_control_out});
      chk("irq pin", 32'h0, {30'h0, host_irq_output_oe, host_irq_output_o});
      rchk(IDX_MISC_CONTROL, 32'h0);
      rchk(IDX_RX_CODE_LOW, 32'h0);
      rchk(IDX_RAM_MAJOR, 32'h0);
   endtask : s_reset_again
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      resetn = 1'b0;
      rx_code_load = 1'b0;
      rx_code_in = 10'h2b6;
      ram_version_in = 16'h0304;
      ram_version_load = 1'b0;
      unmasked_status = 8'h0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      s_reset_values();
      s_code_and_versions();
      s_control();
      s_irq_pin();
      s_reset_again();
      complete_run();
   end
endmodule : misc_control_id_registers_test
`default_nettype wire
